/* File: design/hcd_pkg.sv */
// shared constants and types for the hall commutation host controller
package hcd_pkg;

    // hall codes, first channel is the msb
    localparam logic [2:0] HCD_CODE_S0   = 3'h4;
    localparam logic [2:0] HCD_CODE_S1   = 3'h6;
    localparam logic [2:0] HCD_CODE_S2   = 3'h7;
    localparam logic [2:0] HCD_CODE_S3   = 3'h3;
    localparam logic [2:0] HCD_CODE_S4   = 3'h1;
    localparam logic [2:0] HCD_CODE_S5   = 3'h0;
    localparam logic [2:0] HCD_CODE_BADA = 3'h2;
    localparam logic [2:0] HCD_CODE_BADB = 3'h5;

    // phase driver masks, bit 0 is phase a
    localparam logic [2:0] HCD_PH_A    = 3'h1;
    localparam logic [2:0] HCD_PH_B    = 3'h2;
    localparam logic [2:0] HCD_PH_C    = 3'h4;
    localparam logic [2:0] HCD_PH_NONE = 3'h0;

    localparam int         HCD_CNT_W   = 24;
    localparam int         HCD_SYNC_W  = 4;
    localparam logic [HCD_CNT_W-1:0] HCD_CNT_MAX  = 24'hffffff;
    localparam logic [HCD_CNT_W-1:0] HCD_CNT_ZERO = 24'h000000;
    localparam logic [HCD_CNT_W-1:0] HCD_CNT_ONE  = 24'h000001;

    typedef enum logic [2:0] {
        HCD_IDLE  = 3'h1,
        HCD_RUN   = 3'h2,
        HCD_FAULT = 3'h4
    } hcd_state_t;

    // expected driver commands of the device for the present code
    typedef struct packed {
        logic [2:0] high_side_on;
        logic [2:0] low_side_on;
    } hcd_drv_t;

    // per channel source selection: which motor sensor, and inverted or not
    typedef struct packed {
        logic [1:0] src;
        logic       inv;
    } hcd_map_t;

    // differential drive of one set of hall pins
    typedef struct packed {
        logic [2:0] pos;
        logic [2:0] neg;
        logic [2:0] pos_ref;
    } hcd_hall_t;

    typedef struct packed {
        hcd_state_t           st;
        hcd_hall_t            hall;
        logic [2:0]           code;
        hcd_drv_t             drv;
        logic                 idx_prev;
        logic [HCD_CNT_W-1:0] cnt;
        logic [HCD_CNT_W-1:0] period;
        logic                 fault_seq;
        logic                 fault_code;
    } hcd_top_t;

    typedef struct packed {
        logic [HCD_SYNC_W-1:0] s1;
        logic [HCD_SYNC_W-1:0] s2;
        logic [HCD_SYNC_W-1:0] s3;
        logic [HCD_SYNC_W-1:0] level;
    } hcd_sync_t;

endpackage

/* File: design/hcd_sync.sv */
// three-stage pin synchroniser, a change counts once stages two and three agree
`timescale 1ns/1ps
module hcd_sync (
    input  wire logic                          clk,   // system clock
    input  wire logic                          rst_n, // synchronised reset
    input  wire logic                          ce,    // clock enable
    input  wire logic [hcd_pkg::HCD_SYNC_W-1:0] din,  // raw pin levels
    output logic      [hcd_pkg::HCD_SYNC_W-1:0] dout  // filtered levels
);
    import hcd_pkg::*;

    hcd_sync_t s_reg;
    hcd_sync_t s_next;

    always_comb begin
        s_next = s_reg;
        if (ce) begin
            s_next.s1    = din;
            s_next.s2    = s_reg.s1;
            s_next.s3    = s_reg.s2;
            // stage one is never looked at here, only stages two and three
            s_next.level = (~(s_reg.s2 ^ s_reg.s3) & s_reg.s3)
                         | ((s_reg.s2 ^ s_reg.s3) & s_reg.level);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dout = s_reg.level;
endmodule

/* File: design/hcd_host.sv */
// host controller that feeds hall codes to a brushless driver and watches it
//
// How it works
// - first input rises first, second 30 degrees later, third 30 more.
// - each sensor is high under one of two 90 degree windows 180 apart.
// - forward rotation follows the counter-clockwise code sequence.
// - inverted sensors go to the negative input, positive tied to reference.
`timescale 1ns/1ps
module hcd_host (
    input  wire logic                            CLK,          // 100 MHz clock
    input  wire logic                            ARST_N,       // async reset, active low
    input  wire logic                            CE,           // clock enable
    input  wire logic [2:0]                      MOTOR_SENSOR, // sensor pins a,b,c
    input  wire logic                            SPEED_FB,     // device speed pin level
    input  wire hcd_pkg::hcd_map_t [2:0]         CHAN_MAP,     // per channel source
    input  wire logic                            RUN_EN,       // request motor drive
    input  wire logic                            SEQ_CHECK_EN, // stop on bad step
    output logic      [2:0]                      HALL_POS,     // positive hall inputs
    output logic      [2:0]                      HALL_NEG,     // negative hall inputs
    output logic      [2:0]                      HALL_POS_REF, // pos pin on reference
    output logic                                 INHIBIT,      // device inhibit pin
    output hcd_pkg::hcd_drv_t                    EXPECT_DRV,   // predicted drivers
    output logic [hcd_pkg::HCD_CNT_W-1:0]        SPEED_PERIOD, // clocks per turn
    output logic                                 FAULT_SEQ,    // step out of order
    output logic                                 FAULT_CODE,   // unused code seen
    output logic                                 RUNNING       // drive enabled
);
    import hcd_pkg::*;

    logic       rst_meta;
    logic       rst_n;
    logic [3:0] sync_out;
    logic [2:0] sens;
    logic       idx;
    logic [2:0] raw;
    logic [2:0] code_now;
    hcd_top_t   t_reg;
    hcd_top_t   t_next;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    hcd_sync u_sync (
        .clk   (CLK),
        .rst_n (rst_n),
        .ce    (CE),
        .din   ({SPEED_FB, MOTOR_SENSOR}),
        .dout  (sync_out)
    );

    assign sens = sync_out[2:0];
    assign idx  = sync_out[3];

    // motor sensors are re-ordered and inverted to build the device code
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_chan
            assign raw[g] = (CHAN_MAP[g].src == 2'h1) ? sens[1] :
                            (CHAN_MAP[g].src == 2'h2) ? sens[2] : sens[0];
            // channel 0 feeds the first input, the code msb
            assign code_now[2-g] = raw[g] ^ CHAN_MAP[g].inv;
        end
    endgenerate

    // forward successor in the counter-clockwise window order
    function automatic logic [2:0] next_fwd(input logic [2:0] c);
        case (c)
            HCD_CODE_S0: next_fwd = HCD_CODE_S1;
            HCD_CODE_S1: next_fwd = HCD_CODE_S2;
            HCD_CODE_S2: next_fwd = HCD_CODE_S3;
            HCD_CODE_S3: next_fwd = HCD_CODE_S4;
            HCD_CODE_S4: next_fwd = HCD_CODE_S5;
            HCD_CODE_S5: next_fwd = HCD_CODE_S0;
            default:     next_fwd = c;
        endcase
    endfunction

    // what the device is expected to switch on for a code
    function automatic hcd_drv_t decode(input logic [2:0] c, input logic inh);
        hcd_drv_t d;
        d = '0;
        case (c)
            HCD_CODE_S0: begin
                d.high_side_on = HCD_PH_C;
                d.low_side_on  = HCD_PH_A;
            end
            HCD_CODE_S1: begin
                d.high_side_on = HCD_PH_C;
                d.low_side_on  = HCD_PH_B;
            end
            HCD_CODE_S2: begin
                d.high_side_on = HCD_PH_A;
                d.low_side_on  = HCD_PH_B;
            end
            HCD_CODE_S3: begin
                d.high_side_on = HCD_PH_A;
                d.low_side_on  = HCD_PH_C;
            end
            HCD_CODE_S4: begin
                d.high_side_on = HCD_PH_B;
                d.low_side_on  = HCD_PH_C;
            end
            HCD_CODE_S5: begin
                d.high_side_on = HCD_PH_B;
                d.low_side_on  = HCD_PH_A;
            end
            default: begin
                d.high_side_on = HCD_PH_NONE;
                d.low_side_on  = HCD_PH_NONE;
            end
        endcase
        // the third phase gets neither side and floats
        d.low_side_on = d.low_side_on & ~d.high_side_on;
        if (inh) begin
            d = '0;
        end
        decode = d;
    endfunction

    always_comb begin
        logic code_bad;
        logic step_ok;
        code_bad = 1'b0;
        step_ok  = 1'b0;
        t_next   = t_reg;
        if (CE) begin
            code_bad = (code_now == HCD_CODE_BADA) || (code_now == HCD_CODE_BADB);
            step_ok  = (code_now == t_reg.code) || (code_now == next_fwd(t_reg.code));
            t_next.code = code_now;

            // inverted sensors drive the negative pin, positive held at reference
            t_next.hall.pos_ref = {CHAN_MAP[2].inv, CHAN_MAP[1].inv, CHAN_MAP[0].inv};
            t_next.hall.pos     = raw & ~t_next.hall.pos_ref;
            t_next.hall.neg     = raw & t_next.hall.pos_ref;

            case (t_reg.st)
                HCD_IDLE: begin
                    if (RUN_EN && !code_bad) begin
                        t_next.st = HCD_RUN;
                    end
                end
                HCD_RUN: begin
                    if (!RUN_EN) begin
                        t_next.st = HCD_IDLE;
                    end else if (code_bad) begin
                        t_next.st         = HCD_FAULT;
                        t_next.fault_code = 1'b1;
                    end else if (SEQ_CHECK_EN && !step_ok) begin
                        t_next.st        = HCD_FAULT;
                        t_next.fault_seq = 1'b1;
                    end
                end
                HCD_FAULT: begin
                    // faults hold the device inhibited until the run request drops
                    if (!RUN_EN) begin
                        t_next.st         = HCD_IDLE;
                        t_next.fault_seq  = 1'b0;
                        t_next.fault_code = 1'b0;
                    end
                end
                default: begin
                    t_next.st = HCD_IDLE;
                end
            endcase

            t_next.drv = decode(code_now, t_next.st != HCD_RUN);

            // open-collector feedback, rising edge marks one electrical turn
            t_next.idx_prev = idx;
            if (idx && !t_reg.idx_prev) begin
                t_next.period = t_reg.cnt;
                t_next.cnt    = HCD_CNT_ONE;
            end else if (t_reg.cnt != HCD_CNT_MAX) begin
                t_next.cnt = t_reg.cnt + HCD_CNT_ONE;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            t_reg        <= '0;
            t_reg.st     <= HCD_IDLE;
            t_reg.cnt    <= HCD_CNT_ZERO;
            t_reg.period <= HCD_CNT_ZERO;
        end else begin
            t_reg <= t_next;
        end
    end

    assign HALL_POS     = t_reg.hall.pos;
    assign HALL_NEG     = t_reg.hall.neg;
    assign HALL_POS_REF = t_reg.hall.pos_ref;
    assign INHIBIT      = (t_reg.st != HCD_RUN);
    assign EXPECT_DRV   = t_reg.drv;
    assign SPEED_PERIOD = t_reg.period;
    assign FAULT_SEQ    = t_reg.fault_seq;
    assign FAULT_CODE   = t_reg.fault_code;
    assign RUNNING      = (t_reg.st == HCD_RUN);
endmodule

/* File: sim/hcd_dev_model.sv */
// behavioural three-phase driver: hall decode, floating phase, speed pin
`timescale 1ns/1ps
module hcd_dev_model (
    input  wire logic [2:0]   hall_pos,     // positive hall pins
    input  wire logic [2:0]   hall_neg,     // negative hall pins
    input  wire logic [2:0]   hall_pos_ref, // positive pin on reference
    input  wire logic         inhibit,      // stage inhibit, high = off
    output hcd_pkg::hcd_drv_t drv,          // driver on flags, bit 0 phase a
    output wire               speed_oc      // open collector speed pin
);
    import hcd_pkg::*;
    logic [2:0] h;
    // a channel fed on the negative pin reads inverted against the reference
    assign h = (hall_pos_ref & ~hall_neg) | (~hall_pos_ref & hall_pos);
    // released pin floats, so the bench pull-up decides the high level
    assign speed_oc = h[0] ? 1'bz : 1'b0;
    always_comb begin
        case ({h[0], h[1], h[2]})
            3'h4: drv = {3'h4, 3'h1};
            3'h6: drv = {3'h4, 3'h2};
            3'h7: drv = {3'h1, 3'h2};
            3'h3: drv = {3'h1, 3'h4};
            3'h1: drv = {3'h2, 3'h4};
            3'h0: drv = {3'h2, 3'h1};
            default: drv = {3'h0, 3'h0};
        endcase
        if (inhibit) drv = {3'h0, 3'h0};
    end
endmodule

/* File: sim/hcd_host_chk.sv */
// concurrent checks on the hall commutation host ports
`timescale 1ns/1ps
module hcd_host_chk (
    input wire logic              CLK,          // clock
    input wire logic              ARST_N,       // async reset
    input wire logic              CE,           // clock enable
    input wire logic              RUN_EN,       // drive request
    input wire logic [2:0]        HALL_POS,     // positive hall pins
    input wire logic [2:0]        HALL_NEG,     // negative hall pins
    input wire logic [2:0]        HALL_POS_REF, // positive pin on reference
    input wire logic              INHIBIT,      // inhibit pin
    input wire hcd_pkg::hcd_drv_t EXPECT_DRV,   // predicted drivers
    input wire logic              FAULT_SEQ,    // order fault
    input wire logic              FAULT_CODE,   // code fault
    input wire logic              RUNNING       // drive on
);
    import hcd_pkg::*;
    logic [2:0] h;
    logic       bad;
    // channel order is reversed against the code, but both unused codes are symmetric
    assign h   = (HALL_POS_REF & ~HALL_NEG) | (~HALL_POS_REF & HALL_POS);
    assign bad = (h == 3'h2) || (h == 3'h5);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    inhibit_state_a: assert property (INHIBIT == !RUNNING)
        else $error("inhibit disagrees with run state");
    inhibit_drv_a: assert property (INHIBIT |-> EXPECT_DRV == 6'h00)
        else $error("drivers predicted while inhibited");
    no_shoot_a: assert property ((EXPECT_DRV.high_side_on & EXPECT_DRV.low_side_on) == 3'h0)
        else $error("both drivers of one phase on");
    one_pair_a: assert property (RUNNING && !bad |->
        $onehot(EXPECT_DRV.high_side_on) && $onehot(EXPECT_DRV.low_side_on))
        else $error("floating phase not left off");
    unused_off_a: assert property (bad |-> EXPECT_DRV == 6'h00)
        else $error("drivers on for unused code");
    bad_code_stop_a: assert property (bad |-> !RUNNING && (INHIBIT || !RUN_EN))
        else $error("drive kept on unused code");
    hall_route_a: assert property (
        ((HALL_POS & HALL_POS_REF) | (HALL_NEG & ~HALL_POS_REF)) == 3'h0)
        else $error("hall pin not on reference");
    run_drop_a: assert property (CE && !RUN_EN |=> !RUNNING && !FAULT_SEQ && !FAULT_CODE)
        else $error("drive not dropped on request");
    fault_hold_a: assert property (FAULT_CODE && CE && RUN_EN |=> FAULT_CODE && INHIBIT)
        else $error("code fault released early");
endmodule
bind hcd_host hcd_host_chk u_chk (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .RUN_EN(RUN_EN),
    .HALL_POS(HALL_POS), .HALL_NEG(HALL_NEG), .HALL_POS_REF(HALL_POS_REF), .INHIBIT(INHIBIT),
    .EXPECT_DRV(EXPECT_DRV), .FAULT_SEQ(FAULT_SEQ), .FAULT_CODE(FAULT_CODE), .RUNNING(RUNNING));

/* File: sim/tb_hcd_host.sv */
// self-checking bench: host controller feeding the behavioural driver
`timescale 1ns/1ps
module tb_hcd_host;
    import hcd_pkg::*;
    logic           CLK = 1'b0;
    logic           ARST_N = 1'b0;
    logic           CE = 1'b1;
    logic           RUN_EN = 1'b0;
    logic           SEQ_CHECK_EN = 1'b0;
    logic [2:0]     MOTOR_SENSOR = 3'h0;
    hcd_map_t [2:0] CHAN_MAP = '0;
    logic [2:0]     HALL_POS, HALL_NEG, HALL_POS_REF;
    logic           INHIBIT, FAULT_SEQ, FAULT_CODE, RUNNING;
    hcd_drv_t       EXPECT_DRV, dev_drv;
    logic [23:0]    SPEED_PERIOD;
    tri1            spd_pin;
    logic [33:0]    exp_q[$];
    logic [33:0]    e;
    int             n_errors = 0;
    int             tests_run = 0;
    int             seed = 9;
    event           chk_ev;
    localparam logic [2:0] FWD [6] = '{HCD_CODE_S0, HCD_CODE_S1, HCD_CODE_S2,
                                       HCD_CODE_S3, HCD_CODE_S4, HCD_CODE_S5};

    always #5 CLK = ~CLK;

    hcd_host u_dut (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .MOTOR_SENSOR(MOTOR_SENSOR),
        .SPEED_FB(spd_pin), .CHAN_MAP(CHAN_MAP), .RUN_EN(RUN_EN), .SEQ_CHECK_EN(SEQ_CHECK_EN),
        .HALL_POS(HALL_POS), .HALL_NEG(HALL_NEG), .HALL_POS_REF(HALL_POS_REF), .INHIBIT(INHIBIT),
        .EXPECT_DRV(EXPECT_DRV), .SPEED_PERIOD(SPEED_PERIOD), .FAULT_SEQ(FAULT_SEQ),
        .FAULT_CODE(FAULT_CODE), .RUNNING(RUNNING));
    hcd_dev_model u_dev (.hall_pos(HALL_POS), .hall_neg(HALL_NEG), .hall_pos_ref(HALL_POS_REF),
        .inhibit(INHIBIT), .drv(dev_drv), .speed_oc(spd_pin));

    function automatic logic [5:0] exp_drv(input logic [2:0] c);
        case (c)
            HCD_CODE_S0: return 6'h21;
            HCD_CODE_S1: return 6'h22;
            HCD_CODE_S2: return 6'h0a;
            HCD_CODE_S3: return 6'h0c;
            HCD_CODE_S4: return 6'h14;
            HCD_CODE_S5: return 6'h11;
            default: return 6'h00;
        endcase
    endfunction

    task automatic cmp_drv(input hcd_drv_t got, input hcd_drv_t exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t drivers %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t level %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cmp_cnt(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t period %h expected %h", $time, got, exp);
        end
    endtask

    // random rotation of the sources and random polarity, so inverted channels use the negative pin
    task automatic new_map();
        int r;
        r = $unsigned($random(seed)) % 3;
        @(posedge CLK);
        for (int g = 0; g < 3; g++) CHAN_MAP[g] <= {2'((g + r) % 3), 1'($random(seed))};
    endtask

    // 8 edges a step leave room for the 5 edge sensor latency
    // speed pin adds 5 more, so a new period shows only in the following step
    task automatic step(input logic [2:0] code, input logic inh, fs, fc, input logic [23:0] per);
        @(posedge CLK);
        for (int g = 0; g < 3; g++) MOTOR_SENSOR[CHAN_MAP[g].src] <= code[2-g] ^ CHAN_MAP[g].inv;
        repeat (7) @(posedge CLK);
        #1;
        exp_q.push_back({per, fs, fc, code[2], inh, inh ? 6'h00 : exp_drv(code)});
        -> chk_ev;
    endtask

    always @(chk_ev) begin
        e = exp_q.pop_front();
        cmp_drv(EXPECT_DRV, e[5:0]);
        cmp_drv(dev_drv, e[5:0]);
        cmp_bit(INHIBIT, e[6]);
        cmp_bit(spd_pin, e[7]);
        cmp_bit(FAULT_CODE, e[8]);
        cmp_bit(FAULT_SEQ, e[9]);
        if (e[33:10] !== 24'h0) cmp_cnt(SPEED_PERIOD, e[33:10]);
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge CLK);
        ARST_N <= 1'b1;
        repeat (4) @(posedge CLK);
        new_map();
        for (int c = 0; c < 8; c++) step(3'(c), 1'b1, 1'b0, 1'b0, 24'h0);
        $display("test idle done");
        new_map();
        step(HCD_CODE_S0, 1'b1, 1'b0, 1'b0, 24'h0);
        @(posedge CLK);
        RUN_EN <= 1'b1;
        SEQ_CHECK_EN <= 1'b1;
        // two full turns: one speed pulse per turn, 6 steps of 8 edges apart
        // one step past the last pulse, since its period lands 10 edges after the sensor pins change
        for (int k = 0; k < 14; k++) begin
            step(FWD[k % 6], 1'b0, 1'b0, 1'b0, (k == 13) ? 24'h30 : 24'h0);
        end
        $display("test rotation done");
        step(HCD_CODE_BADA, 1'b1, 1'b0, 1'b1, 24'h0);
        @(posedge CLK);
        RUN_EN <= 1'b0;
        step(HCD_CODE_BADB, 1'b1, 1'b0, 1'b0, 24'h0);
        @(posedge CLK);
        RUN_EN <= 1'b1;
        step(HCD_CODE_BADB, 1'b1, 1'b0, 1'b0, 24'h0);
        step(HCD_CODE_S4, 1'b0, 1'b0, 1'b0, 24'h0);
        step(HCD_CODE_S2, 1'b1, 1'b1, 1'b0, 24'h0);
        @(posedge CLK);
        RUN_EN <= 1'b0;
        step(HCD_CODE_S2, 1'b1, 1'b0, 1'b0, 24'h0);
        $display("test faults done");
        // order check off: a backward step keeps the drive on
        @(posedge CLK);
        RUN_EN <= 1'b1;
        SEQ_CHECK_EN <= 1'b0;
        step(HCD_CODE_S4, 1'b0, 1'b0, 1'b0, 24'h0);
        step(HCD_CODE_S2, 1'b0, 1'b0, 1'b0, 24'h0);
        $display("test free order done");
        @(posedge CLK);
        final_report();
    end
endmodule
